// [decoder_pkg.sv]
// Shared constants and carriers for the prefix instruction decoder.
// Assumes a byte-wide instruction stream and a 32-bit datapath around it.
`default_nettype none
package decoder_pkg;

  localparam int WORD_W = 32;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_JUMP       = 4'h0;
  localparam logic [3:0] FN_PREFIX     = 4'h2;
  localparam logic [3:0] FN_LOAD_CONST = 4'h4;
  localparam logic [3:0] FN_NEGPFX     = 4'h6;
  localparam logic [3:0] FN_ADD_CONST  = 4'h8;
  localparam logic [3:0] FN_COND_JUMP  = 4'hA;
  localparam logic [3:0] FN_OPR        = 4'hF;

  // Base cycles per function code, entry 0 first; opr comes from the datapath
  localparam logic [7:0] BASE_CYC [16] = '{8'h03, 8'h01, 8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h02,
                                           8'h01, 8'h07, 8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h00};
  localparam logic [7:0] CJ_TAKEN_CYC = 8'h04;
  localparam logic [7:0] PREFIX_CYC   = 8'h01;

  // Operation code with a documented value
  localparam logic [WORD_W-1:0] OP_LOAD_ID = 32'h0000017C;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IDENT  = 4'h8;
  localparam logic [3:0] REG_LAST   = 4'hC;
  localparam int CTRL_BREAK_EN  = 0;
  localparam int ST_FAULT       = 0;
  localparam int ST_FLOAT_FAULT = 1;
  localparam int ST_HALTED      = 2;
  localparam logic [WORD_W-1:0] CTRL_RESET = 32'h00000000;

  typedef struct packed {
    logic [3:0]        func;
    logic [WORD_W-1:0] operand;
    logic              is_opr;
    logic              desched;
    logic              may_fault;
    logic              float_sel;
    logic [3:0]        prefixes;
    logic [7:0]        cycles;
  } decoded_s;

  typedef struct packed {
    logic [3:0]        addr;
    logic [WORD_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

endpackage
`default_nettype wire

// [prefix_instruction_decoder.sv]
// Byte-serial prefix instruction decoder with halt, fault and float dispatch.
// Assumes the fetch path offers bytes with valid/ready and the datapath
// supplies register A, shift count, message bounds and opr cycle figures.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`default_nettype none
module prefix_instruction_decoder
  import decoder_pkg::*;
#(
  parameter logic [WORD_W-1:0] ID_BASE    = 32'h00000046,  // Arbitrary value
  parameter logic [WORD_W-1:0] ID_VARIANT = 32'h00000000,  // 0..9, arbitrary
  parameter int                N_DESCHED  = 11,
  parameter int                N_FAULT    = 16,
  // Operate codes that are descheduling points (feature D)
  parameter logic [WORD_W-1:0] DESCHED_OPS [N_DESCHED] = '{32'h07, 32'h0B, 32'h0E, 32'h0F, 32'h51,
                                                           32'h2B, 32'h55, 32'h44, 32'h21, 32'h03,
                                                           32'h0D},
  // Operate codes that may alter the fault flag (feature E)
  parameter logic [WORD_W-1:0] FAULT_OPS [N_FAULT] = '{32'h05, 32'h0C, 32'h53, 32'h2C, 32'h1F,
                                                       32'h16, 32'h38, 32'h1A, 32'h10, 32'h29,
                                                       32'h56, 32'h13, 32'h4C, 32'h4D, 32'h72,
                                                       32'h83},
  parameter logic [WORD_W-1:0] OP_FLOAT_ENTRY = 32'h000000AB,
  parameter logic [WORD_W-1:0] OP_FLOAT_CHECK = 32'h00000083,
  parameter logic [WORD_W-1:0] OP_SHIFT_LEFT  = 32'h00000041,
  parameter logic [WORD_W-1:0] OP_SHIFT_RIGHT = 32'h00000040
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  // Instruction byte stream
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  output logic                   byte_ready,
  // Datapath context
  input  wire logic [WORD_W-1:0] reg_a,
  input  wire logic [5:0]        shift_count,
  input  wire logic [WORD_W-1:0] msg_addr,
  input  wire logic [WORD_W-1:0] msg_len,
  input  wire logic [7:0]        opr_cycles,
  input  wire logic              cj_taken,
  input  wire logic              fault_event,
  // Float unit
  input  wire logic              fpu_busy,
  input  wire logic              float_fault_flag,
  output logic                   fpu_issue,
  output logic [WORD_W-1:0]      fpu_select,
  // Pins
  input  wire logic              halt_request,
  output logic                   halted,
  // Decoded instruction
  output logic                   instr_valid,
  output decoded_s               instr,
  output logic                   push_identity,
  output logic [WORD_W-1:0]      identity_value,
  output logic                   bp_swap,
  output logic [5:0]             var_b,
  output logic [WORD_W-1:0]      var_w,
  output logic                   fault_flag,
  // Register port
  input  wire reg_req_s          reg_req,
  output logic [WORD_W-1:0]      reg_rdata
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] highest_bit(input logic [WORD_W-1:0] v);
    logic [5:0] idx;
    idx = '0;
    for (int i = 0; i < WORD_W; i++) begin
      if (v[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [WORD_W-1:0] msg_words(input logic [WORD_W-1:0] addr,
                                                  input logic [WORD_W-1:0] len);
    logic [WORD_W+1:0] span;
    span = {2'b00, len} + {{WORD_W{1'b0}}, addr[1:0]} + 34'h3;
    return span[WORD_W+1:2];
  endfunction

  function automatic logic in_list_d(input logic [WORD_W-1:0] op);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_DESCHED; i++) begin
      if (DESCHED_OPS[i] == op) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic in_list_e(input logic [WORD_W-1:0] op);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_FAULT; i++) begin
      if (FAULT_OPS[i] == op) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] operand_r;
  logic [3:0]        prefix_cnt_r;
  logic              halted_r;
  logic              fault_r;
  logic [WORD_W-1:0] ctrl_r;
  logic              float_pending_r;

  logic [3:0]        fn;
  logic [3:0]        nib;
  logic [WORD_W-1:0] merged;
  logic              is_prefix;
  logic              accept;
  logic              final_byte;
  logic              is_opr;
  logic              is_float;
  logic              is_desched;
  logic              is_fault_op;
  logic [7:0]        base_cyc;
  logic [7:0]        total_cyc;

  assign fn     = byte_data[7:4];
  assign nib    = byte_data[3:0];
  assign merged = operand_r | {{(WORD_W-4){1'b0}}, nib};
  assign is_prefix = (fn == FN_PREFIX) || (fn == FN_NEGPFX);
  assign is_opr    = (fn == FN_OPR);
  assign is_float  = is_opr && (merged == OP_FLOAT_ENTRY);

  // Only a float dispatch waits on the unit, while it is busy or one was just issued; integer work streams on
  assign byte_ready = rst_n_r && !halted_r && !(is_float && (fpu_busy || float_pending_r));
  assign accept     = ce && byte_valid && byte_ready;
  assign final_byte = accept && !is_prefix;

  // Feature D: jump function or listed operate codes
  assign is_desched = (fn == FN_JUMP) || (is_opr && in_list_d(merged));
  // Feature E: add constant or listed operate codes
  assign is_fault_op = (fn == FN_ADD_CONST) || (is_opr && in_list_e(merged));

  always_comb begin
    base_cyc = BASE_CYC[fn];
    if (is_opr) begin
      base_cyc = opr_cycles;
      if ((merged == OP_SHIFT_LEFT) || (merged == OP_SHIFT_RIGHT)) begin
        base_cyc = 8'(opr_cycles + {2'b00, shift_count});
      end
    end else if ((fn == FN_COND_JUMP) && cj_taken) begin
      base_cyc = CJ_TAKEN_CYC;
    end
    total_cyc = 8'(base_cyc + 8'(prefix_cnt_r) * PREFIX_CYC);
  end

  // Operand accumulation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      operand_r    <= '0;
      prefix_cnt_r <= '0;
    end else if (!rst_n_r) begin
      operand_r    <= '0;
      prefix_cnt_r <= '0;
    end else if (ce && accept) begin
      if (fn == FN_PREFIX) begin
        operand_r    <= merged << 4;
        prefix_cnt_r <= 4'(prefix_cnt_r + 4'h1);
      end else if (fn == FN_NEGPFX) begin
        operand_r    <= (~merged) << 4;
        prefix_cnt_r <= 4'(prefix_cnt_r + 4'h1);
      end else begin
        operand_r    <= '0;
        prefix_cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_valid   <= 1'b0;
      instr         <= '0;
      push_identity <= 1'b0;
      bp_swap       <= 1'b0;
    end else if (!rst_n_r) begin
      instr_valid   <= 1'b0;
      push_identity <= 1'b0;
      bp_swap       <= 1'b0;
    end else if (ce) begin
      instr_valid   <= final_byte;
      push_identity <= final_byte && is_opr && (merged == OP_LOAD_ID);
      bp_swap       <= final_byte && (fn == FN_JUMP) && (merged == '0) && ctrl_r[CTRL_BREAK_EN];
      if (final_byte) begin
        instr.func      <= fn;
        instr.operand   <= merged;
        instr.is_opr    <= is_opr;
        instr.desched   <= is_desched;
        instr.may_fault <= is_fault_op;
        instr.float_sel <= is_float;
        instr.prefixes  <= prefix_cnt_r;
        instr.cycles    <= total_cyc;
      end
    end
  end

  // Variable cycle terms follow the datapath context each cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      var_b <= '0;
      var_w <= '0;
    end else if (ce) begin
      var_b <= highest_bit(reg_a);
      var_w <= msg_words(msg_addr, msg_len);
    end
  end

  // Identity within a block of ten
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      identity_value <= '0;
    end else if (ce) begin
      identity_value <= ID_BASE + ((ID_VARIANT > 32'h9) ? 32'h9 : ID_VARIANT);
    end
  end

  // ----------------------------------------------------------------
  // Float dispatch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fpu_issue       <= 1'b0;
      fpu_select      <= '0;
      float_pending_r <= 1'b0;
    end else if (ce) begin
      fpu_issue       <= final_byte && is_float;
      float_pending_r <= final_byte && is_float;
      if (final_byte && is_float) begin
        fpu_select <= reg_a;
      end
    end
  end

  // ----------------------------------------------------------------
  // Halt at descheduling points
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halted_r <= 1'b0;
    end else if (ce) begin
      if (final_byte && is_desched && halt_request) begin
        halted_r <= 1'b1;
      end else if (!halt_request) begin
        halted_r <= 1'b0;
      end
    end
  end

  assign halted = halted_r;

  // ----------------------------------------------------------------
  // Fault flag
  // ----------------------------------------------------------------
  logic fault_clear;
  logic fault_set;

  assign fault_clear = reg_req.wr && (reg_req.addr == REG_STATUS) && reg_req.wdata[ST_FAULT];
  // Events from other instructions are dropped, not deferred
  assign fault_set = (fault_event && instr_valid && instr.may_fault)
                   || (final_byte && is_opr && (merged == OP_FLOAT_CHECK) && float_fault_flag);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_r <= 1'b0;
    end else if (ce) begin
      if (fault_set) begin
        fault_r <= 1'b1;
      end else if (fault_clear) begin
        fault_r <= 1'b0;
      end
    end
  end

  assign fault_flag = fault_r;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (ce && reg_req.wr && (reg_req.addr == REG_CTRL)) begin
      ctrl_r <= {{(WORD_W-1){1'b0}}, reg_req.wdata[CTRL_BREAK_EN]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_req.rd) begin
        case (reg_req.addr)
          REG_CTRL:   reg_rdata <= ctrl_r;
          REG_STATUS: reg_rdata <= {{(WORD_W-3){1'b0}}, halted_r, float_fault_flag, fault_r};
          REG_IDENT:  reg_rdata <= identity_value;
          REG_LAST:   reg_rdata <= {16'h0000, instr.cycles, instr.prefixes, instr.func};
          default:    reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule // prefix_instruction_decoder
`default_nettype wire

// [decoder_properties.sv]
// Port checker for the prefix instruction decoder.
// Assumes it is bound onto the decoder top with the clock enable high.
`default_nettype none
module decoder_properties
  import decoder_pkg::*;
#(
  parameter logic [WORD_W-1:0] ID_BASE        = 32'h00000046,
  parameter logic [WORD_W-1:0] OP_FLOAT_CHECK = 32'h00000083
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              ce,
  // Byte stream
  input wire logic              byte_valid,
  input wire logic [7:0]        byte_data,
  input wire logic              byte_ready,
  // Datapath, float unit and pins
  input wire logic [WORD_W-1:0] reg_a,
  input wire logic              float_fault_flag,
  input wire logic              fpu_issue,
  input wire logic [WORD_W-1:0] fpu_select,
  input wire logic              halt_request,
  input wire logic              halted,
  // Decoded instruction
  input wire logic              instr_valid,
  input wire decoded_s          instr,
  input wire logic              push_identity,
  input wire logic [WORD_W-1:0] identity_value,
  input wire logic              fault_flag
);
  logic taken;
  logic pfx;
  logic after_pfx_r;
  assign taken = ce && byte_valid && byte_ready;
  assign pfx = byte_data[7:4] == FN_PREFIX || byte_data[7:4] == FN_NEGPFX;
  // Raw reset is enough: byte_ready stays low until the synced copy lets go
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      after_pfx_r <= 1'b0;
    else if (taken)
      after_pfx_r <= pfx;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------
  // Properties
  // ------
  chk_prefix_silent: assert property (taken && pfx |=> !instr_valid)
    else $error("prefix byte completed an instruction");
  chk_single_byte: assert property (
    taken && !pfx && !after_pfx_r |=> instr_valid && instr.prefixes == 4'h0
      && instr.operand == {28'h0, $past(byte_data[3:0])})
    else $error("single byte decoded wrongly");
  chk_ident_push: assert property (
    push_identity |-> instr_valid && instr.is_opr && instr.operand == OP_LOAD_ID)
    else $error("identity push without identity load");
  chk_ident_range: assert property (
    push_identity |-> identity_value >= ID_BASE && identity_value <= ID_BASE + 32'h9)
    else $error("identity outside its block");
  chk_halt_point: assert property ($rose(halted) |-> $past(halt_request) && !byte_ready)
    else $error("halt without request");
  chk_fault_source: assert property (
    $rose(fault_flag) |-> ($past(instr_valid) && $past(instr.may_fault))
      || (instr_valid && instr.is_opr && instr.operand == OP_FLOAT_CHECK))
    else $error("fault set by a non fault instruction");
  chk_float_fault: assert property (
    instr_valid && instr.is_opr && instr.operand == OP_FLOAT_CHECK && float_fault_flag |=> fault_flag)
    else $error("float fault not carried over");
  chk_float_select: assert property (
    fpu_issue |-> instr.float_sel && fpu_select == $past(reg_a))
    else $error("float selector wrong");
endmodule // decoder_properties
`default_nettype wire

// [fetch_model.sv]
// Instruction fetch path model offering queued bytes with valid/ready.
// Assumes the bench pushes bytes into q; slow adds an idle cycle per byte.
`default_nettype none
module fetch_model (
  // Clock and pace
  input  wire logic       clk,
  input  wire logic       slow,
  // Byte stream
  input  wire logic       byte_ready,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic       idle;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    idle = 1'b0;
  end
  // Idle data toggles so a stale byte is never mistaken for a fresh one
  always @(posedge clk) begin
    idle = 1'b0;
    if (byte_valid && byte_ready) begin
      void'(q.pop_front());
      idle = slow;
    end
    byte_valid <= q.size() != 0 && !idle;
    byte_data <= (q.size() != 0 && !idle) ? q[0] : ~byte_data;
  end
endmodule // fetch_model
`default_nettype wire

// [test_prefix_instruction_decoder.sv]
// Self-checking bench for the prefix instruction decoder.
// Assumes the fetch model file and the port checker file.
`default_nettype none
module test_prefix_instruction_decoder;
  import decoder_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WORD_W-1:0] ID_B = 32'h00000091;  // Arbitrary
  localparam logic [WORD_W-1:0] ID_V = 32'h00000003;  // Arbitrary
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              ce = 1'b1;
  logic              slow = 1'b0;
  logic              cj_taken = 1'b0;
  logic              fault_event = 1'b0;
  logic              fpu_busy = 1'b0;
  logic              float_fault_flag = 1'b0;
  logic              halt_request = 1'b0;
  logic [7:0]        opr_cycles = 8'h02;
  logic [5:0]        shift_count = 6'h00;
  logic [WORD_W-1:0] reg_a = '0;
  logic [WORD_W-1:0] msg_addr = '0;
  logic [WORD_W-1:0] msg_len = '0;
  reg_req_s          reg_req = '0;
  logic              byte_valid, byte_ready, fpu_issue, halted, instr_valid, push_identity, bp_swap, fault_flag;
  logic [7:0]        byte_data;
  logic [5:0]        var_b;
  logic [WORD_W-1:0] fpu_select, identity_value, var_w, reg_rdata, rd;
  decoded_s          instr;
  int                n_fail = 0;
  int                cmp_count = 0;
  always #20 clk = ~clk;
  prefix_instruction_decoder #(.ID_BASE(ID_B), .ID_VARIANT(ID_V)) dut (
    .clk(clk), .reset_n(reset_n), .ce(ce),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .reg_a(reg_a), .shift_count(shift_count), .msg_addr(msg_addr), .msg_len(msg_len),
    .opr_cycles(opr_cycles), .cj_taken(cj_taken), .fault_event(fault_event),
    .fpu_busy(fpu_busy), .float_fault_flag(float_fault_flag), .fpu_issue(fpu_issue),
    .fpu_select(fpu_select), .halt_request(halt_request), .halted(halted),
    .instr_valid(instr_valid), .instr(instr), .push_identity(push_identity),
    .identity_value(identity_value), .bp_swap(bp_swap), .var_b(var_b), .var_w(var_w),
    .fault_flag(fault_flag), .reg_req(reg_req), .reg_rdata(reg_rdata));
  fetch_model fetch (.clk(clk), .slow(slow), .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data));
  // ------
  // Shared tasks
  // ------
  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic push(input logic [7:0] b);
    fetch.q.push_back(b);
  endtask
  // Final byte: wait for its one-cycle completion pulse
  task automatic go(input logic [7:0] b);
    int i = 0;
    push(b);
    do begin
      tick(1);
      i++;
    end while (instr_valid !== 1'b1 && i < 50);
    cmp("instr_valid", 32'(instr_valid), 32'h1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) reg_req <= '0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk) reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) reg_req <= '0;
    #1 rd = reg_rdata;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_decode();
    go(8'h43);
    cmp("short operand", instr.operand, 32'h3);
    push(8'h29);
    push(8'h28);
    go(8'h47);
    cmp("long operand", instr.operand, 32'h987);
    cmp("long cycles", 32'(instr.cycles), 32'(BASE_CYC[4] + 8'h02));
    cmp("prefix count", 32'(instr.prefixes), 32'h2);
    @(posedge clk) cj_taken <= 1'b1;
    go(8'hA3);
    cmp("taken jump cycles", 32'(instr.cycles), 32'(CJ_TAKEN_CYC));
    @(posedge clk) cj_taken <= 1'b0;
    push(8'h61);
    go(8'h41);
    cmp("negative operand", instr.operand, 32'hFFFFFFE1);
    go(8'h45);
    cmp("operand cleared", instr.operand, 32'h5);
    $display("test decode done");
  endtask
  task automatic t_operate();
    @(posedge clk) slow <= 1'b1;
    go(8'hF5);
    cmp("short opcode", instr.operand, 32'h5);
    cmp("short is opr", 32'(instr.is_opr), 32'h1);
    push(8'h21);
    go(8'hF6);
    cmp("long opcode", instr.operand, 32'h16);
    cmp("long opr cycles", 32'(instr.cycles), 32'h3);
    @(posedge clk) shift_count <= 6'h05;
    push(8'h24);
    go(8'hF1);
    cmp("shift cycles", 32'(instr.cycles), 32'h8);
    push(8'h21);
    push(8'h27);
    go(8'hFC);
    cmp("identity push", 32'(push_identity), 32'h1);
    cmp("identity value", identity_value, ID_B + ID_V);
    @(posedge clk) slow <= 1'b0;
    $display("test operate done");
  endtask
  task automatic t_float();
    @(posedge clk) reg_a <= 32'h0000000B;
    push(8'h2A);
    go(8'hFB);
    cmp("float issue", 32'(fpu_issue), 32'h1);
    cmp("float select", fpu_select, 32'hB);
    cmp("float sel mark", 32'(instr.float_sel), 32'h1);
    @(posedge clk) fpu_busy <= 1'b1;
    go(8'h43);
    cmp("integer while busy", instr.operand, 32'h3);
    @(posedge clk) fpu_busy <= 1'b0;
    reg_a <= 32'h00012345;
    msg_addr <= 32'h2;
    msg_len <= 32'h8;
    tick(3);
    cmp("top bit", 32'(var_b), 32'h10);
    cmp("message words", var_w, 32'h3);
    $display("test float done");
  endtask
  task automatic t_halt();
    @(posedge clk) halt_request <= 1'b1;
    go(8'h43);
    tick(1);
    cmp("no halt off point", 32'(halted), 32'h0);
    go(8'h05);
    cmp("jump desched", 32'(instr.desched), 32'h1);
    tick(1);
    cmp("halt at point", 32'(halted), 32'h1);
    cmp("fetch stalled", 32'(byte_ready), 32'h0);
    @(posedge clk) halt_request <= 1'b0;
    tick(2);
    cmp("halt released", 32'(halted), 32'h0);
    $display("test halt done");
  endtask
  task automatic t_fault();
    @(posedge clk) fault_event <= 1'b1;
    go(8'h43);
    tick(1);
    cmp("no fault load", 32'(fault_flag), 32'h0);
    go(8'h81);
    tick(1);
    cmp("fault add const", 32'(fault_flag), 32'h1);
    @(posedge clk) fault_event <= 1'b0;
    rd_reg(REG_STATUS);
    cmp("status fault", rd, 32'h1);
    wr(REG_STATUS, 32'h1);
    push(8'h28);
    go(8'hF3);
    tick(1);
    cmp("float clear kept", 32'(fault_flag), 32'h0);
    @(posedge clk) float_fault_flag <= 1'b1;
    push(8'h28);
    go(8'hF3);
    tick(1);
    cmp("float fault set", 32'(fault_flag), 32'h1);
    @(posedge clk) float_fault_flag <= 1'b0;
    $display("test fault done");
  endtask
  task automatic t_regs();
    rd_reg(REG_CTRL);
    cmp("ctrl reset", rd, CTRL_RESET);
    rd_reg(REG_IDENT);
    cmp("ident reg", rd, ID_B + ID_V);
    wr(4'h2, 32'hFFFFFFFF);
    rd_reg(4'h2);
    cmp("unmapped", rd, 32'h0);
    wr(REG_CTRL, 32'h1);
    go(8'h00);
    cmp("break swap", 32'(bp_swap), 32'h1);
    wr(REG_CTRL, 32'h0);
    go(8'h00);
    cmp("plain jump", 32'(bp_swap), 32'h0);
    $display("test regs done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    t_decode();
    t_operate();
    t_float();
    t_halt();
    t_fault();
    t_regs();
    tally_and_finish();
  end
  initial begin
    #(40 * 4000);
    n_fail++;
    tally_and_finish();
  end
endmodule // test_prefix_instruction_decoder
bind prefix_instruction_decoder decoder_properties #(.ID_BASE(ID_BASE), .OP_FLOAT_CHECK(OP_FLOAT_CHECK)) chk (
  .clk(clk), .reset_n(reset_n), .ce(ce), .byte_valid(byte_valid), .byte_data(byte_data),
  .byte_ready(byte_ready), .reg_a(reg_a), .float_fault_flag(float_fault_flag), .fpu_issue(fpu_issue),
  .fpu_select(fpu_select), .halt_request(halt_request), .halted(halted), .instr_valid(instr_valid),
  .instr(instr), .push_identity(push_identity), .identity_value(identity_value), .fault_flag(fault_flag));
`default_nettype wire
